// ===== verilog/param_ctl_pkg.sv
// Package of constants for the network parameter control block
// How it works
// RULE1: On completion the status word is written with zero for success or a nonzero error code for failure.
// RULE2: Flag bit 0 marks the network configuration table as supplied, otherwise it is absent.
// RULE3: Flag bit 1 marks the reserved station table as supplied, otherwise it is ignored.
// RULE4: Flag bit 2 marks the error-invalid station table as supplied, otherwise it is ignored.
// RULE5: Any table whose flag is zero is replaced by built-in default parameters.
// RULE6: Flag bit 8 set holds faulty-station data, clear clears it.
// RULE7: Flag bit 9 set clears outputs while the processor is stopped, clear holds them.
// RULE8: Flag bit 11 set selects ring topology, clear selects line, star or mixed.
// RULE9: Flag bit 12 set holds outputs on processor error, clear clears them.
// RULE10: The issuer writes a slave station count from 1 to 120 into the third word.
// RULE11: A field out of its range ends the command with an error and applies nothing.
// RULE12: A local station applies only flag bits 8 and 9 and ignores other changes silently.
// RULE13: Completion pulses the done bit for one scan, with the error bit beside it on failure.
// RULE14: Station entries beyond the configured count are ignored; the count wins.
// RULE15: The issuer zeroes unused bits and words and reads status only after done is seen.
package param_ctl_pkg;
  localparam logic [1:0] ADDR_STATUS = 2'h0;
  localparam logic [1:0] ADDR_FLAGS = 2'h1;
  localparam logic [1:0] ADDR_COUNT = 2'h2;
  localparam logic [1:0] ADDR_UNUSED = 2'h3;
  localparam int BIT_CFG_VALID = 0;
  localparam int BIT_RSV_VALID = 1;
  localparam int BIT_ERRINV_VALID = 2;
  localparam int BIT_FAULT_HOLD = 8;
  localparam int BIT_STOP_CLEAR = 9;
  localparam int BIT_RING = 11;
  localparam int BIT_ERR_HOLD = 12;
  localparam logic [15:0] FLAGS_USED_MASK = 16'h1b07;
  localparam logic [15:0] COUNT_MIN = 16'h0001;
  localparam logic [15:0] COUNT_MAX = 16'h0078;
  localparam logic [15:0] STATUS_OK = 16'h0000;
  localparam logic [15:0] ERR_FLAGS_RANGE = 16'hc001;
  localparam logic [15:0] ERR_COUNT_RANGE = 16'hc002;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [6:0] DEFAULT_COUNT = 7'h78;
  localparam logic [15:0] DEFAULT_FLAGS = 16'h0000;
  typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_APPLY, ST_DONE} cmd_state_e;
endpackage : param_ctl_pkg

// ===== verilog/param_range_check.sv
// Range checker for the control block fields
module param_range_check
  import param_ctl_pkg::*;
(
  input wire logic [15:0] flags, // Setting flag word
  input wire logic [15:0] count, // Slave station count word
  input wire logic local_mode, // Local station startup
  output logic [15:0] code // Zero or error code
);
  always_comb
  begin
    code = STATUS_OK;
    if (!local_mode && ((flags & ~FLAGS_USED_MASK) != RESET_WORD))
    begin
      code = ERR_FLAGS_RANGE; // see RULE11
    end
    else if (!local_mode && (count < COUNT_MIN || count > COUNT_MAX))
    begin
      code = ERR_COUNT_RANGE; // see RULE11
    end
  end
endmodule : param_range_check

// ===== verilog/network_param_control_block.sv
// Interpreter of the parameter-set control block
module network_param_control_block
  import param_ctl_pkg::*;
(
  input wire logic mclk, // Clock
  input wire logic nrst, // Async reset, active low
  input wire logic wr_en, // Block word write strobe
  input wire logic [1:0] wr_addr, // Block word index
  input wire logic [15:0] wr_data, // Write data
  input wire logic [1:0] rd_addr, // Read index
  output logic [15:0] rd_data, // Read data, combinational
  input wire logic start, // Command start pulse
  input wire logic local_mode, // Startup as local station
  output logic busy, // Command in progress
  output logic done, // Completion, one cycle
  output logic error, // Error completion, one cycle
  output logic cfg_valid, // Configuration table used
  output logic rsv_valid, // Reserved table used
  output logic errinv_valid, // Error-invalid table used
  output logic use_defaults, // Some table takes defaults
  output logic fault_hold, // Faulty station data held
  output logic stop_clear, // Outputs cleared on stop
  output logic ring_topology, // Ring selected
  output logic err_hold, // Outputs held on processor error
  output logic [6:0] active_stations // Stations taken into account
);
  import param_ctl_pkg::*;

  cmd_state_e state_q;
  logic [15:0] status_q;
  logic [15:0] flags_q;
  logic [15:0] count_q;
  logic [15:0] applied_q;
  logic [6:0] stations_q;
  logic done_q;
  logic error_q;
  logic local_q;
  logic [15:0] check_code;
  logic [15:0] applied_d;

  param_range_check i_param_range_check (
    .flags(flags_q),
    .count(count_q),
    .local_mode(local_q),
    .code(check_code)
  );

  // Block words written by the issuer; ignored while a command runs
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      flags_q <= RESET_WORD;
      count_q <= RESET_WORD;
    end
    else if (wr_en && state_q == ST_IDLE)
    begin
      if (wr_addr == ADDR_FLAGS)
      begin
        flags_q <= wr_data;
      end
      else if (wr_addr == ADDR_COUNT)
      begin
        count_q <= wr_data;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= ST_IDLE;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (start)
          begin
            state_q <= ST_CHECK;
          end
        end
        ST_CHECK:
        begin
          // A failed check skips APPLY so nothing is taken
          state_q <= (check_code == STATUS_OK) ? ST_APPLY : ST_DONE; // see RULE11
        end
        ST_APPLY:
        begin
          state_q <= ST_DONE;
        end
        ST_DONE:
        begin
          state_q <= ST_IDLE;
        end
        default:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Station role latched with start so one command never mixes both decisions
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      local_q <= 1'b0;
    end
    else if (state_q == ST_IDLE && start)
    begin
      local_q <= local_mode; // see RULE12
    end
  end

  // Status word
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      status_q <= STATUS_OK;
    end
    else if (state_q == ST_CHECK)
    begin
      status_q <= check_code; // see RULE1
    end
  end

  // Local station keeps earlier settings except the fault and stop bits
  for (genvar b = 0; b < $bits(flags_q); b++)
  begin : g_applied
    if (b == BIT_FAULT_HOLD || b == BIT_STOP_CLEAR)
    begin : g_taken
      assign applied_d[b] = flags_q[b]; // see RULE12
    end
    else
    begin : g_kept
      assign applied_d[b] = local_q ? applied_q[b] : flags_q[b]; // see RULE12
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      applied_q <= DEFAULT_FLAGS;
    end
    else if (state_q == ST_APPLY)
    begin
      applied_q <= applied_d & FLAGS_USED_MASK;
    end
  end

  // Only the configured count survives; station entries past it are dropped
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      stations_q <= DEFAULT_COUNT;
    end
    else if (state_q == ST_APPLY && !local_q)
    begin
      stations_q <= count_q[$bits(stations_q)-1:0]; // see RULE14
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= (state_q == ST_DONE); // see RULE13
    end
  end

  // Error flag rides on the done pulse of a failed command
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      error_q <= 1'b0;
    end
    else
    begin
      error_q <= (state_q == ST_DONE) && (status_q != STATUS_OK); // see RULE13
    end
  end

  always_comb
  begin
    case (rd_addr)
      ADDR_STATUS: rd_data = status_q;
      ADDR_FLAGS: rd_data = flags_q;
      ADDR_COUNT: rd_data = count_q;
      default: rd_data = RESET_WORD;
    endcase
  end

  // Busy spans CHECK to DONE; writes and start are refused then
  assign busy = (state_q != ST_IDLE);
  assign done = done_q;
  assign error = error_q;
  // Flag outputs follow the applied copy, not the words being written
  assign cfg_valid = applied_q[BIT_CFG_VALID]; // see RULE2
  assign rsv_valid = applied_q[BIT_RSV_VALID]; // see RULE3
  assign errinv_valid = applied_q[BIT_ERRINV_VALID]; // see RULE4
  assign use_defaults = !(cfg_valid && rsv_valid && errinv_valid); // see RULE5
  assign fault_hold = applied_q[BIT_FAULT_HOLD]; // see RULE6
  assign stop_clear = applied_q[BIT_STOP_CLEAR]; // see RULE7
  assign ring_topology = applied_q[BIT_RING]; // see RULE8
  assign err_hold = applied_q[BIT_ERR_HOLD]; // see RULE9
  assign active_stations = stations_q; // see RULE14
endmodule : network_param_control_block

// ===== testbench/network_param_control_block_chk.sv
// Port checks for the parameter control block
module network_param_control_block_chk (
  input wire logic mclk, // Clock
  input wire logic nrst, // Reset
  input wire logic start, // Start
  input wire logic busy, // Busy
  input wire logic done, // Done
  input wire logic error, // Error
  input wire logic cfg_valid, // Table
  input wire logic rsv_valid, // Table
  input wire logic errinv_valid, // Table
  input wire logic use_defaults, // Defaults
  input wire logic fault_hold, // Mode
  input wire logic stop_clear, // Mode
  input wire logic ring_topology, // Mode
  input wire logic err_hold, // Mode
  input wire logic [6:0] active_stations // Count
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  wire [10:0] outs = {cfg_valid, rsv_valid, errinv_valid, fault_hold, stop_clear, ring_topology, err_hold, 4'h0};
  property p_err_done; error |-> done; endproperty
  a_err_done: assert property (p_err_done) else $error("error without done");
  property p_pulse; done |=> !done; endproperty
  a_pulse: assert property (p_pulse) else $error("done too long");
  property p_answer; start && !busy |-> ##[3:4] done; endproperty
  a_answer: assert property (p_answer) else $error("no completion");
  property p_idle; done |-> !busy; endproperty
  a_idle: assert property (p_idle) else $error("busy at done");
  property p_busy; start && !busy |=> busy; endproperty
  a_busy: assert property (p_busy) else $error("start not taken");
  property p_steady; !busy ##1 !busy |-> $stable(outs) && $stable(active_stations); endproperty
  a_steady: assert property (p_steady) else $error("change while idle");
  property p_keep; error |-> $stable(outs) && $stable(active_stations); endproperty
  a_keep: assert property (p_keep) else $error("applied on error");
  property p_dflt; use_defaults == !(cfg_valid && rsv_valid && errinv_valid); endproperty
  a_dflt: assert property (p_dflt) else $error("defaults wrong");
  property p_cnt; active_stations inside {[1:120]}; endproperty
  a_cnt: assert property (p_cnt) else $error("count out of range");
  cover property (done && !error);
  cover property (error);
  cover property (done && ring_topology);
endmodule : network_param_control_block_chk

// ===== testbench/param_cpu_model.sv
// Processor model that fills the control block and issues commands
module param_cpu_model
  import param_ctl_pkg::*;
(
  input wire logic mclk, // Clock
  input wire logic done, // Done
  input wire logic error, // Error
  input wire logic [15:0] rd_data, // Read data
  output logic wr_en, // Write
  output logic [1:0] wr_addr, // Index
  output logic [15:0] wr_data, // Data
  output logic [1:0] rd_addr, // Read index
  output logic start, // Start
  output logic local_mode // Local
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {wr_en, wr_addr, wr_data, rd_addr, start, local_mode} = '0;
  task wr(input logic [1:0] a, input logic [15:0] d);
    @(negedge mclk) {wr_addr, wr_data, wr_en} = {a, d, 1'b1};
    @(negedge mclk) {wr_data, wr_en} = {~d, 1'b0};
  endtask : wr
  task rd(input logic [1:0] a, output logic [15:0] d);
    @(negedge mclk) rd_addr = a;
    #1 d = rd_data;
  endtask : rd
  task cmd(input logic loc, output logic e, output logic [15:0] st);
    int n;
    @(negedge mclk) {local_mode, start} = {loc, 1'b1};
    @(negedge mclk) start = 1'b0;
    for (n = 0; n < 8 && done !== 1'b1; n++) @(negedge mclk);
    // Unknown flags a missing completion
    e = (done === 1'b1) ? error : 1'bx;
    rd(ADDR_STATUS, st);
  endtask : cmd
endmodule : param_cpu_model

// ===== testbench/network_param_control_block_tb_top.sv
// Testbench for the parameter control block
module network_param_control_block_tb_top
  import param_ctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, nrst = 0, wr_en, start, local_mode, busy, done, error, e;
  logic [1:0] wr_addr, rd_addr;
  logic [15:0] wr_data, rd_data, st, ex, mf = '0, mc = 16'h0078;
  logic cfg_valid, rsv_valid, errinv_valid, use_defaults, fault_hold, stop_clear, ring_topology, err_hold;
  logic [6:0] active_stations;
  int bad_count = 0, compares = 0, cyc = 0;
  wire [15:0] outs = {1'b0, cfg_valid, rsv_valid, errinv_valid, use_defaults, fault_hold, stop_clear,
    ring_topology, err_hold, active_stations};
  network_param_control_block i_network_param_control_block (.*);
  param_cpu_model i_param_cpu_model (.*);
  task check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task tally_and_finish;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  function automatic logic [15:0] exp_outs();
    return {1'b0, mf[0], mf[1], mf[2], ~&mf[2:0], mf[8], mf[9], mf[11], mf[12], mc[6:0]};
  endfunction : exp_outs
  task run(input logic [15:0] f, input logic [15:0] c, input logic loc);
    ex = loc ? STATUS_OK : |(f & ~FLAGS_USED_MASK) ? ERR_FLAGS_RANGE :
      (c < COUNT_MIN || c > COUNT_MAX) ? ERR_COUNT_RANGE : STATUS_OK;
    i_param_cpu_model.wr(ADDR_FLAGS, f);
    i_param_cpu_model.wr(ADDR_COUNT, c);
    i_param_cpu_model.rd(ADDR_COUNT, st);
    check(st, c);
    i_param_cpu_model.cmd(loc, e, st);
    check(st, ex);
    check({15'h0, e}, {15'h0, ex != STATUS_OK});
    if (ex == STATUS_OK && loc) mf[9:8] = f[9:8];
    else if (ex == STATUS_OK) {mf, mc} = {f, c};
    check(outs, exp_outs());
    $display("test done flags %h count %h local %b", f, c, loc);
  endtask : run
  initial forever #20 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc > 2000)
    begin
      bad_count++;
      tally_and_finish;
    end
  end
  initial
  begin
    repeat (4) @(negedge mclk);
    nrst = 1'b1;
    check(outs, exp_outs());
    i_param_cpu_model.rd(ADDR_UNUSED, st);
    check(st, 16'h0000);
    run(16'h1b07, 16'h0078, 1'b0);
    run(16'h0000, 16'h0001, 1'b0);
    run(16'h0a05, 16'h0002, 1'b0);
    run(16'h0010, 16'h0005, 1'b0);
    run(16'h0000, 16'h0079, 1'b0);
    run(16'h0000, 16'h0000, 1'b0);
    run(16'h1b07, 16'h0005, 1'b1);
    tally_and_finish;
  end
endmodule : network_param_control_block_tb_top
bind network_param_control_block network_param_control_block_chk i_network_param_control_block_chk (
  .mclk(mclk),
  .nrst(nrst),
  .start(start),
  .busy(busy),
  .done(done),
  .error(error),
  .cfg_valid(cfg_valid),
  .rsv_valid(rsv_valid),
  .errinv_valid(errinv_valid),
  .use_defaults(use_defaults),
  .fault_hold(fault_hold),
  .stop_clear(stop_clear),
  .ring_topology(ring_topology),
  .err_hold(err_hold),
  .active_stations(active_stations)
);
